// ===== src/adc_timing_cfg.svh
// Purpose: Constants for the converter timing block.
// Assumes: One master clock; counts are in master clock cycles.
// Notes: Included by the package and the design module.
`ifndef ADC_TIMING_CFG_SVH
`define ADC_TIMING_CFG_SVH

`define DIV_300 10'h200
`define DIV_1200 10'h080
`define DIV_9600 10'h010
`define DIV_19200 10'h008
`define SEL_300 2'h0
`define SEL_1200 2'h1
`define SEL_9600 2'h2
`define SEL_19200 2'h3
`define OVERSAMPLE 5'h10
`define CONV_HI_COMP 19'h4e200
`define CONV_HI_UNCOMP 19'h27100
`define CONV_LO_COMP 19'h13880
`define CONV_LO_UNCOMP 19'h09c40
`define ONE_DIV 10'h001
`define ONE_CONV 19'h00001
`define ONE_BIT 4'h1

`endif

// ===== src/adc_timing_pkg.sv
// Purpose: Types for the converter timing block.
// Assumes: Constants come from the cfg header.
// Notes: Holds the conversion state type.
`include "adc_timing_cfg.svh"
package adc_timing_pkg;
	typedef logic [9:0] div_type;
	typedef logic [18:0] conv_count_type;
	typedef enum logic [1:0] {
		st_idle,
		st_run
	} conv_state_type;
endpackage : adc_timing_pkg

// ===== src/adc_baud_and_conversion_timing.sv
// Purpose: Data clock and conversion duration timing for a dual-slope converter.
// Assumes: Inputs synchronous to clk_in; all state frozen while ce_in is low.
// Notes: Parallel and synchronous-serial paths do not use the data clock.
//        Every count advances only on edges where ce_in is high.
//
// What this block does
// R1: Divide master clock by 512/128/16/8 per baud.
// R2: Data clock is sixteen times bit rate.
// R3: Conversion lasts fixed cycles by resolution, compensation.
// R4: Low-res uncompensated conversion lasts 40,000 cycles.
// R5: Parallel and synchronous rates ignore master clock.
// R6: Baud scales proportionally with master clock.
// R7: Host programs its UART divider to match.
// R8: Continuous mode overwrites results every conversion.
// R9: Free-running divider counter with one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
`include "adc_timing_cfg.svh"
module adc_baud_and_conversion_timing (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic [1:0] baud_sel_in,
	input wire logic async_mode_in,
	input wire logic start_in,
	input wire logic continuous_in,
	input wire logic high_res_in,
	input wire logic compensated_in,
	input wire logic [23:0] result_in,
	output logic data_clk_en_out,
	output logic bit_tick_out,
	output logic converting_out,
	output logic conv_done_out,
	output logic updated_out,
	output logic [23:0] result_out
);
	import adc_timing_pkg::*;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	function automatic div_type divider_of(input logic [1:0] sel);
		case (sel)
			`SEL_300: begin
				divider_of = `DIV_300; // [R1]
			end
			`SEL_1200: begin
				divider_of = `DIV_1200; // [R1]
			end
			`SEL_9600: begin
				divider_of = `DIV_9600; // [R1]
			end
			default: begin
				divider_of = `DIV_19200; // [R1]
			end
		endcase
	endfunction : divider_of

	function automatic conv_count_type duration_of(input logic hi, input logic comp);
		case ({hi, comp})
			2'h3: begin
				duration_of = `CONV_HI_COMP; // [R3]
			end
			2'h2: begin
				duration_of = `CONV_HI_UNCOMP; // [R3]
			end
			2'h1: begin
				duration_of = `CONV_LO_COMP; // [R3]
			end
			default: begin
				duration_of = `CONV_LO_UNCOMP; // [R4]
			end
		endcase
	endfunction : duration_of

	// ----------------------------------------
	// Data clock decode
	// ----------------------------------------
	// Counting in master cycles makes every rate track the clock, so a nonstandard
	// clock shifts the baud and the host must match it with its own divider.
	div_type div_cnt_ff;
	div_type nxt_div_cnt;
	logic [3:0] bit_cnt_ff;
	logic [3:0] nxt_bit_cnt;
	logic div_wrap;
	logic data_pulse;

	// Greater-or-equal keeps a shortened divider change from running away.
	always_comb begin
		div_wrap = (div_cnt_ff >= divider_of(baud_sel_in) - `ONE_DIV); // [R1]
		data_pulse = div_wrap && async_mode_in; // [R5]
		if (div_wrap) begin
			nxt_div_cnt = '0; // [R9]
		end else begin
			nxt_div_cnt = div_cnt_ff + `ONE_DIV; // [R6]
		end
		if (data_pulse) begin
			nxt_bit_cnt = bit_cnt_ff + `ONE_BIT; // [R2]
		end else begin
			nxt_bit_cnt = bit_cnt_ff;
		end
	end

	// ----------------------------------------
	// Divider counter
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			div_cnt_ff <= '0;
			data_clk_en_out <= 1'b0;
		end else if (ce_in) begin
			div_cnt_ff <= nxt_div_cnt; // [R9] [R6]
			data_clk_en_out <= data_pulse; // [R9] [R5]
		end
	end

	// ----------------------------------------
	// Bit ticks
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			bit_cnt_ff <= '0;
			bit_tick_out <= 1'b0;
		end else if (ce_in) begin
			bit_cnt_ff <= nxt_bit_cnt; // [R2]
			bit_tick_out <= data_pulse && (bit_cnt_ff == 4'(`OVERSAMPLE - 5'h01)); // [R2]
		end
	end

	// ----------------------------------------
	// Conversion timing
	// ----------------------------------------
	conv_state_type state_ff;
	conv_count_type conv_cnt_ff;
	conv_count_type reload_len;
	logic cont_ff;
	wire logic conv_end = (state_ff == st_run) && (conv_cnt_ff == `ONE_CONV);

	// Sampled at every start and every reload, so a continuous run follows a
	// change of resolution or compensation from the next conversion on.
	always_comb begin
		reload_len = duration_of(high_res_in, compensated_in); // [R3] [R4]
	end

	// ----------------------------------------
	// Repeat flag
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			cont_ff <= 1'b0;
		end else if (ce_in && state_ff == st_idle && start_in) begin
			cont_ff <= continuous_in; // [R8]
		end
	end

	// ----------------------------------------
	// Conversion counter
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_ff <= st_idle;
			conv_cnt_ff <= '0;
		end else if (ce_in) begin
			case (state_ff)
				st_idle: begin
					if (start_in) begin
						state_ff <= st_run;
						conv_cnt_ff <= reload_len; // [R3]
					end
				end
				st_run: begin
					if (conv_end) begin
						// Continuous mode reloads at once; results never wait for the host.
						if (cont_ff) begin
							conv_cnt_ff <= reload_len; // [R8]
						end else begin
							state_ff <= st_idle;
							conv_cnt_ff <= '0;
						end
					end else begin
						conv_cnt_ff <= conv_cnt_ff - `ONE_CONV; // [R3] [R4]
					end
				end
				default: state_ff <= st_idle;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			conv_done_out <= 1'b0;
			converting_out <= 1'b0;
		end else if (ce_in) begin
			// A single conversion drops its busy level on the same edge as done.
			conv_done_out <= conv_end;
			converting_out <= (state_ff == st_run) && !(conv_end && !cont_ff);
		end
	end

	// ----------------------------------------
	// Result capture
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			result_out <= '0;
			updated_out <= 1'b0;
		end else if (ce_in) begin
			if (conv_end) begin
				result_out <= result_in; // [R8]
				updated_out <= 1'b1;
			end else if (start_in && state_ff == st_idle) begin
				updated_out <= 1'b0;
			end
		end
	end
endmodule : adc_baud_and_conversion_timing
`default_nettype wire

// ===== tb/timing_chk_properties.sv
// Purpose: Port checks for the timing block.
// Assumes: One clock; ce_in held high by the bench.
// Notes: Only the low-res uncompensated length is timed here.
`timescale 1ns/1ps
`default_nettype none
module timing_chk (
	input wire logic clk_in, nrst_in, async_mode_in, start_in, ce_in, high_res_in, compensated_in,
	input wire logic [1:0] baud_sel_in,
	input wire logic [23:0] result_in, result_out,
	input wire logic data_clk_en_out, bit_tick_out, converting_out, conv_done_out, updated_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	logic [18:0] run_ff;
	sequence s_gap;
		!data_clk_en_out [*7] ##1 data_clk_en_out;
	endsequence
	// Restarting at one on each end keeps back-to-back runs the same length.
	always_ff @(posedge clk_in) begin
		if (!converting_out)
			run_ff <= 19'h00001;
		else
			run_ff <= conv_done_out ? 19'h00001 : run_ff + 19'h00001;
	end
	a_fast_div: assert property (data_clk_en_out && baud_sel_in == 2'h3 |=> s_gap) else $error("gap");
	a_en_pulse: assert property (data_clk_en_out |=> !data_clk_en_out) else $error("enable");
	a_tick_gap: assert property (bit_tick_out |=> !bit_tick_out [*8]) else $error("tick");
	a_async_gate: assert property (!async_mode_in [*2] |-> !data_clk_en_out) else $error("gate");
	a_start_runs: assert property (start_in && ce_in && !converting_out |-> ##2 converting_out) else $error("start");
	a_done_ends: assert property (conv_done_out |-> $past(converting_out) && updated_out) else $error("end");
	a_result_load: assert property (conv_done_out |-> result_out == $past(result_in)) else $error("result");
	a_lo_length: assert property (conv_done_out && !high_res_in && !compensated_in |-> run_ff == 19'h09c40)
		else $error("length");
endmodule : timing_chk
`default_nettype wire

// ===== tb/host_uart_model.sv
// Purpose: Host receiver that times the device bit clock.
// Assumes: Host divider set to match the device data clock.
// Notes: Gives the span between the last two bit ticks.
`timescale 1ns/1ps
`default_nettype none
module host_uart_model (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic tick_in,
	output logic [15:0] period_out,
	output logic [7:0] ticks_out
);
	logic [15:0] cnt_ff;
	always_ff @(posedge clk_in) begin
		cnt_ff <= (tick_in || !nrst_in) ? 16'h0001 : cnt_ff + 16'h0001;
		period_out <= !nrst_in ? 16'h0000 : (tick_in ? cnt_ff : period_out);
		ticks_out <= !nrst_in ? 8'h00 : ticks_out + {7'h00, tick_in};
	end
endmodule : host_uart_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Bench for the timing block.
// Assumes: ce_in held high throughout.
// Notes: Conversion runs are long, so only the shortest kind is run.
`timescale 1ns/1ps
`default_nettype none
`include "adc_timing_cfg.svh"
module testbench;
	logic clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1, async_mode_in = 1'b0, start_in = 1'b0;
	logic continuous_in = 1'b0, high_res_in = 1'b0, compensated_in = 1'b0;
	logic [1:0] baud_sel_in = 2'h0;
	logic [23:0] result_in = 24'h000000, result_out;
	logic data_clk_en_out, bit_tick_out, converting_out, conv_done_out, updated_out;
	logic [15:0] per;
	logic [7:0] ticks;
	int errors = 0, compares = 0;
	adc_baud_and_conversion_timing uut (.*);
	host_uart_model host (.clk_in(clk_in), .nrst_in(nrst_in), .tick_in(bit_tick_out), .period_out(per), .ticks_out(ticks));
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wait_done(output int t);
		t = 0;
		do begin
			@(negedge clk_in);
			t++;
		end while (conv_done_out !== 1'b1 && t < 50000);
	endtask : wait_done
	task automatic test_divider;
		logic [9:0] d [4] = '{`DIV_300, `DIV_1200, `DIV_9600, `DIV_19200};
		logic [7:0] n;
		repeat (600) @(negedge clk_in) check("gated", 0, data_clk_en_out);
		for (int s = 0; s < 4; s++) begin
			async_mode_in = 1'b0;
			repeat (4) @(negedge clk_in);
			baud_sel_in = 2'(s);
			async_mode_in = 1'b1;
			n = ticks;
			for (int i = 0; i < 20000 && ticks != n + 8'h02; i++) @(negedge clk_in);
			check("bit_period", {d[s], 4'h0}, per);
		end
		$display("test_divider done");
	endtask : test_divider
	task automatic test_conv;
		int t;
		continuous_in = 1'b1;
		result_in = 24'h5a3c96;
		start_in = 1'b1;
		@(negedge clk_in) start_in = 1'b0;
		wait_done(t);
		check("first_done", 32'h00009c40, t);
		check("result", 24'h5a3c96, result_out);
		check("updated", 1, updated_out);
		check("converting", 1, converting_out);
		result_in = 24'hc3a50f;
		wait_done(t);
		check("period", 32'h00009c40, t);
		check("result", 24'hc3a50f, result_out);
		$display("test_conv done");
	endtask : test_conv
	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (16) @(negedge clk_in);
		nrst_in = 1'b1;
		test_divider();
		test_conv();
		report_and_stop();
	end
	initial begin
		#1200000;
		errors++;
		report_and_stop();
	end
endmodule : testbench
bind adc_baud_and_conversion_timing timing_chk chk (.*);
`default_nettype wire
